// file: ictc_pkg.sv
/*
  ictc_pkg: constants, types and register map of the idle and cpu throttle control block.
  Assumes a 32-bit classic Wishbone register bus, one register per aligned word.
*/
package ictc_pkg;

  localparam logic [3:0] ICTC_OFS_REGULATOR = 4'h0;
  localparam logic [3:0] ICTC_OFS_THROTTLE  = 4'h4;

  // regulator_control layout
  localparam int         ICTC_REG_LP_BIT     = 1;
  localparam logic [7:0] ICTC_REG_FIXED_ONES = 8'h01;
  localparam logic [7:0] ICTC_REG_RESET      = 8'h01;

  // cpu_throttle_control layout
  localparam int         ICTC_THR_IDLE_BIT = 7;
  localparam int         ICTC_THR_EN_BIT   = 6;
  localparam int         ICTC_THR_ROI_BIT  = 5;
  localparam int         ICTC_THR_DOE_BIT  = 4;
  localparam logic [7:0] ICTC_THR_RESET    = 8'h00;
  localparam logic [2:0] ICTC_RATIO_RESET  = 3'h0;

  typedef enum logic [2:0] {
    ICTC_RUN   = 3'b001,
    ICTC_IDLE  = 3'b010,
    ICTC_SLEEP = 3'b100
  } ictc_mode_e;

  // one-cycle events from the cpu core
  typedef struct packed {
    logic sleep_exec;
    logic isr_entry;
    logic irq_return;
  } ictc_cpu_ev_s;

  // wake sources
  typedef struct packed {
    logic irq_pending;
    logic wdt_timeout;
    logic sleep_wake;
  } ictc_wake_s;

endpackage

// file: ictc_ratio_gate.sv
/*
  ictc_ratio_gate: counts peripheral instruction cycles and grants one cpu
  cycle every 2^(ratio+1) of them while throttling; every cycle otherwise.
  Assumes the peripheral instruction-cycle enable on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ictc_ratio_gate
  import ictc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic       clk_i,         // system clock
  input  wire logic       rst_i,         // sync reset, high
  input  wire logic       periph_cyc_i,  // peripheral cycle enable
  input  wire logic       throttle_i,    // throttling active
  input  wire logic [2:0] ratio_i,       // ratio code
  output logic            cpu_cyc_o      // cpu cycle enable
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] limit;

  // code n gives 1:2^(n+1)
  assign limit = CNT_W'((9'h002 << ratio_i) - 9'h001);

  always_ff @(posedge clk_i) begin
    if (rst_i || !throttle_i) begin
      count <= '0;
    end else if (periph_cyc_i) begin
      count <= (count >= limit) ? '0 : count + 1'b1;
    end
  end

  assign cpu_cyc_o = periph_cyc_i && (!throttle_i || count == '0);

endmodule
`default_nettype wire

// file: ictc_top.sv
/*
  ictc_top: idle/sleep selection, cpu halt and throttle control with its
  two software registers on a classic Wishbone slave.
  Assumes the cpu core pulses its events for one clock and the peripheral
  instruction-cycle enable comes from a divider on clk_i.
*/
// The register addresses and the Wishbone slave port were chosen for this implementation.
// Function
// - idle_select picks Idle or Sleep on sleep
// - Idle halts cpu and flash, peripherals run
// - sys-osc peripherals run in Idle, not Sleep
// - clock output keeps toggling in Idle
// - enabled interrupt ends Idle; idle_select kept
// - later sleep with idle_select re-enters Idle
// - interrupt waking Idle restores full speed if recovering
// - watchdog wakes Idle, no reset, no recovery
// - regulator low-power select bit 1, resets 0
// - regulator bits 7-2 read 0, bit 0 reads 1
// - throttle_enable gates cpu cycles by ratio
// - isr entry clears throttle_enable if recovering
// - return sets throttle_enable if throttle_on_return
// - debug forces full speed, stored bit kept
// - Sleep only while idle_select is clear
`timescale 1ns/100ps
`default_nettype none
module ictc_top
  import ictc_pkg::*;
(
  input  wire logic         clk_i,              // system clock, 10 MHz
  input  wire logic         rst_i,              // sync reset, high
  input  wire logic         cyc_i,              // wishbone cycle
  input  wire logic         stb_i,              // wishbone strobe
  input  wire logic         we_i,               // wishbone write
  input  wire logic [3:0]   adr_i,              // wishbone byte address
  input  wire logic [3:0]   sel_i,              // wishbone byte select
  input  wire logic [31:0]  dat_i,              // wishbone write data
  output logic [31:0]       dat_o,              // wishbone read data
  output logic              ack_o,              // wishbone ack
  input  wire ictc_cpu_ev_s cpu_ev_i,           // cpu one-cycle events
  input  wire logic         irq_pending_i,      // enabled irq flag set
  input  wire logic         wdt_timeout_i,      // watchdog time-out
  input  wire logic         sleep_wake_i,       // sleep wake event
  input  wire logic         debug_active_i,     // in-circuit debug
  input  wire logic         periph_cyc_i,       // peripheral cycle enable
  input  wire logic         clock_output_function_cfg_n_i,     // clock output cfg, low on
  output logic              cpu_cyc_o,          // cpu cycle enable
  output logic              cpu_halt_o,         // cpu and flash halted
  output logic              flash_en_o,         // program flash active
  output logic              fosc_periph_en_o,   // sys-osc periph clocks
  output logic              intosc_periph_en_o, // internal osc periph clocks
  output logic              clock_output_function_en_o,        // clock output toggling
  output logic              wdt_reset_block_o,  // watchdog reset blocked
  output logic              reg_lowpower_o,     // regulator lp in sleep
  output logic              idle_o,             // in Idle
  output logic              sleep_o             // in Sleep
);

  ictc_mode_e mode;
  ictc_mode_e next_mode;
  ictc_wake_s wake;
  logic       idle_select;
  logic       throttle_enable;
  logic       recover_on_interrupt;
  logic       throttle_on_return;
  logic [2:0] ratio;
  logic       regulator_lowpower_select;
  logic       wr_thr;
  logic       wr_reg;
  logic       bus_req;
  logic [7:0] rd_byte;
  logic       gate_cyc;
  logic       throttle_active;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a[3:2] == ofs[3:2]);
  endfunction

  // one driver for the whole struct
  assign wake = '{irq_pending: irq_pending_i, wdt_timeout: wdt_timeout_i, sleep_wake: sleep_wake_i};

  // wishbone slave, one registered ack per request, one wait state
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_thr  = bus_req && we_i && sel_i[0] && hit(adr_i, ICTC_OFS_THROTTLE);
  assign wr_reg  = bus_req && we_i && sel_i[0] && hit(adr_i, ICTC_OFS_REGULATOR);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_comb begin
    if (hit(adr_i, ICTC_OFS_REGULATOR)) begin
      rd_byte = ICTC_REG_FIXED_ONES;
      rd_byte[ICTC_REG_LP_BIT] = regulator_lowpower_select;
    end else if (hit(adr_i, ICTC_OFS_THROTTLE)) begin
      rd_byte = {idle_select, throttle_enable, recover_on_interrupt,
                 throttle_on_return, 1'b0, ratio};
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // regulator register; bit 0 is fixed, so a cleared write has no effect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regulator_lowpower_select <= ICTC_REG_RESET[ICTC_REG_LP_BIT];
    end else if (wr_reg) begin
      regulator_lowpower_select <= dat_i[ICTC_REG_LP_BIT];
    end
  end

  // idle select: software only, no wake touches it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_select <= ICTC_THR_RESET[ICTC_THR_IDLE_BIT];
    end else if (wr_thr) begin
      idle_select <= dat_i[ICTC_THR_IDLE_BIT];
    end
  end

  // recover-on-interrupt select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recover_on_interrupt <= ICTC_THR_RESET[ICTC_THR_ROI_BIT];
    end else if (wr_thr) begin
      recover_on_interrupt <= dat_i[ICTC_THR_ROI_BIT];
    end
  end

  // throttle-on-return select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      throttle_on_return <= ICTC_THR_RESET[ICTC_THR_DOE_BIT];
    end else if (wr_thr) begin
      throttle_on_return <= dat_i[ICTC_THR_DOE_BIT];
    end
  end

  // throttle ratio code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ratio <= ICTC_RATIO_RESET;
    end else if (wr_thr) begin
      ratio <= dat_i[2:0];
    end
  end

  // throttle enable: hardware events first, then software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      throttle_enable <= ICTC_THR_RESET[ICTC_THR_EN_BIT];
    end else if (cpu_ev_i.isr_entry && recover_on_interrupt) begin
      throttle_enable <= 1'b0;
    end else if (mode == ICTC_IDLE && wake.irq_pending && recover_on_interrupt) begin
      throttle_enable <= 1'b0;
    end else if (cpu_ev_i.irq_return && throttle_on_return) begin
      throttle_enable <= 1'b1;
    end else if (wr_thr) begin
      throttle_enable <= dat_i[ICTC_THR_EN_BIT];
    end
  end

  // power mode sequencing
  always_comb begin
    next_mode = mode;
    case (mode)
      ICTC_RUN: begin
        if (cpu_ev_i.sleep_exec) begin
          next_mode = idle_select ? ICTC_IDLE : ICTC_SLEEP;
        end
      end
      ICTC_IDLE: begin
        if (wake.irq_pending || wake.wdt_timeout) begin
          next_mode = ICTC_RUN;
        end
      end
      ICTC_SLEEP: begin
        if (wake.sleep_wake || wake.irq_pending) begin
          next_mode = ICTC_RUN;
        end
      end
      default: next_mode = ICTC_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= ICTC_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  assign throttle_active = throttle_enable && !debug_active_i;

  ictc_ratio_gate #(
    .CNT_W (8)
  ) u_gate (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .periph_cyc_i (periph_cyc_i),
    .throttle_i   (throttle_active),
    .ratio_i      (ratio),
    .cpu_cyc_o    (gate_cyc)
  );

  assign cpu_cyc_o          = gate_cyc && mode == ICTC_RUN;
  assign cpu_halt_o         = mode != ICTC_RUN;
  assign flash_en_o         = mode == ICTC_RUN;
  assign fosc_periph_en_o   = mode != ICTC_SLEEP;
  assign intosc_periph_en_o = 1'b1;
  assign clock_output_function_en_o        = !clock_output_function_cfg_n_i && mode != ICTC_SLEEP;
  assign wdt_reset_block_o  = mode == ICTC_IDLE;
  assign reg_lowpower_o     = regulator_lowpower_select;
  assign idle_o             = mode == ICTC_IDLE;
  assign sleep_o            = mode == ICTC_SLEEP;

endmodule
`default_nettype wire

// file: ictc_top_properties.sv
/* ictc_top_properties: port checker for ictc_top.
   Assumes it is bound into every ictc_top. */
`timescale 1ns/100ps
`default_nettype none
module ictc_top_properties
  import ictc_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         cyc_i,
  input wire logic         stb_i,
  input wire logic         ack_o,
  input wire ictc_cpu_ev_s cpu_ev_i,
  input wire logic         irq_pending_i,
  input wire logic         wdt_timeout_i,
  input wire logic         debug_active_i,
  input wire logic         periph_cyc_i,
  input wire logic         clock_output_function_cfg_n_i,
  input wire logic         cpu_cyc_o,
  input wire logic         cpu_halt_o,
  input wire logic         flash_en_o,
  input wire logic         fosc_periph_en_o,
  input wire logic         clock_output_function_en_o,
  input wire logic         wdt_reset_block_o,
  input wire logic         idle_o,
  input wire logic         sleep_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_enter; cpu_ev_i.sleep_exec && !idle_o && !sleep_o |=> idle_o ^ sleep_o; endproperty
  a_enter: assert property (p_enter) else $error("no mode entry");
  property p_halt; idle_o |-> cpu_halt_o && !flash_en_o && !cpu_cyc_o && fosc_periph_en_o; endproperty
  a_halt: assert property (p_halt) else $error("idle halt wrong");
  property p_sleep; sleep_o |-> !fosc_periph_en_o && !idle_o; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
  property p_clko; idle_o && !clock_output_function_cfg_n_i |-> clock_output_function_en_o; endproperty
  a_clko: assert property (p_clko) else $error("clock output stopped");
  property p_wake; idle_o && irq_pending_i |=> !idle_o; endproperty
  a_wake: assert property (p_wake) else $error("irq kept idle");
  property p_wdt; idle_o && wdt_timeout_i |-> wdt_reset_block_o ##1 !idle_o; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog wake wrong");
  property p_dbg; debug_active_i && !idle_o && !sleep_o |-> cpu_cyc_o == periph_cyc_i; endproperty
  a_dbg: assert property (p_dbg) else $error("debug not full speed");
  property p_gate; cpu_cyc_o |-> periph_cyc_i; endproperty
  a_gate: assert property (p_gate) else $error("cpu cycle off grid");
  c_idle: cover property (idle_o && irq_pending_i);
  c_sleep: cover property (sleep_o);
  c_dbg: cover property (debug_active_i && cpu_cyc_o);
endmodule
bind ictc_top ictc_top_properties ictc_top_properties_i (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .cpu_ev_i,
  .irq_pending_i, .wdt_timeout_i, .debug_active_i, .periph_cyc_i, .clock_output_function_cfg_n_i, .cpu_cyc_o, .cpu_halt_o,
  .flash_en_o, .fosc_periph_en_o, .clock_output_function_en_o, .wdt_reset_block_o, .idle_o, .sleep_o);
`default_nettype wire

// file: ictc_cpu_model.sv
/* ictc_cpu_model: cpu core side, event pulses and peripheral cycles.
   Assumes bench requests as levels on clk_i. */
`timescale 1ns/100ps
`default_nettype none
module ictc_cpu_model
  import ictc_pkg::*;
#(
  parameter int PDIV = 2
) (
  input  wire logic         clk_i,        // bench clock
  input  wire logic         rst_i,        // sync reset, high
  input  wire ictc_cpu_ev_s req_i,        // event requests, levels
  output ictc_cpu_ev_s      ev_o,         // one-clock event pulses
  output logic              periph_cyc_o  // peripheral cycle enable
);
  ictc_cpu_ev_s prev;
  int           div;
  always_ff @(posedge clk_i) begin
    prev <= rst_i ? '0 : req_i;
    ev_o <= rst_i ? '0 : req_i & ~prev; // one clock per event
  end
  always_ff @(posedge clk_i) begin
    div          <= (rst_i || div == PDIV - 1) ? 0 : div + 1;
    periph_cyc_o <= !rst_i && div == PDIV - 1;
  end
endmodule
`default_nettype wire

// file: test_idle_and_cpu_throttle_control.sv
/* test_idle_and_cpu_throttle_control: queue-checked bench of ictc_top.
   Assumes ictc_cpu_model as the cpu core. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module test_idle_and_cpu_throttle_control
  import ictc_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, debug_active_i = 0, clock_output_function_cfg_n_i = 1;
  logic [3:0]  adr_i = '0, sel_i = 4'hF;
  logic [31:0] dat_i = '0, dat_o;
  logic [2:0]  wk = '0;
  logic        ack_o, periph_cyc_i, cpu_cyc_o, cpu_halt_o, flash_en_o, fosc_periph_en_o, intosc_periph_en_o;
  logic        clock_output_function_en_o, wdt_reset_block_o, reg_lowpower_o, idle_o, sleep_o;
  ictc_cpu_ev_s req = '0, cpu_ev_i;
  logic [7:0]  exp_q[$], exp_rd;
  int          miscompares = 0, check_count = 0;
  ictc_cpu_model ictc_cpu_model_i (.clk_i, .rst_i, .req_i(req), .ev_o(cpu_ev_i), .periph_cyc_o(periph_cyc_i));
  ictc_top ictc_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .cpu_ev_i,
    .irq_pending_i(wk[2]), .wdt_timeout_i(wk[1]), .sleep_wake_i(wk[0]), .debug_active_i, .periph_cyc_i,
    .clock_output_function_cfg_n_i, .cpu_cyc_o, .cpu_halt_o, .flash_en_o, .fosc_periph_en_o, .intosc_periph_en_o, .clock_output_function_en_o,
    .wdt_reset_block_o, .reg_lowpower_o, .idle_o, .sleep_o);
  initial forever #50 clk_i = ~clk_i;
  task automatic conclude;
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= {24'h0, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    cyc_i <= 0; stb_i <= 0;
    if (n >= 20) begin miscompares++; conclude(); end
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wb(0, a, 8'h00);
  endtask
  task automatic ev(input ictc_cpu_ev_s e);
    req <= e; @(posedge clk_i); req <= '0; repeat (3) @(posedge clk_i);
  endtask
  task automatic pulse(input logic [2:0] m);
    wk <= m; @(posedge clk_i); wk <= '0; repeat (2) @(posedge clk_i);
  endtask
  task automatic win(input int p, input int e);
    int np, nc, n;
    np = 0; nc = 0; n = 0;
    while (np < p && n < 5000) begin
      @(posedge clk_i); np += (periph_cyc_i === 1'b1); nc += (cpu_cyc_o === 1'b1); n++;
    end
    if (n >= 5000) begin miscompares++; conclude(); end
    `CHK(nc, e)
  endtask
  always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) begin
    exp_rd = exp_q.pop_front();
    `CHK(dat_o[7:0], exp_rd)
  end
  initial begin
    logic [7:0] d, tw[4], tx[4];
    tw = '{8'h67, 8'h47, 8'h17, 8'h07};
    tx = '{8'h27, 8'h47, 8'h57, 8'h07};
    void'($urandom(32'h4AD467FE));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(4'h0, 8'h01); rd(4'h4, 8'h00); rd(4'h8, 8'h00);
    `CHK(clock_output_function_en_o, 1'b0)
    d = 8'($urandom()) | 8'h01;
    wb(1, 4'h0, d); rd(4'h0, {6'h00, d[1], 1'b1});
    `CHK(reg_lowpower_o, d[1])
    for (int c = 0; c < 8; c++) begin wb(1, 4'h4, {5'h08, 3'(c)}); win(4 << c, 2); end
    wb(1, 4'h4, 8'h07); win(8, 8);
    wb(1, 4'h4, 8'h47); debug_active_i <= 1; win(8, 8); debug_active_i <= 0; rd(4'h4, 8'h47);
    for (int i = 0; i < 4; i++) begin wb(1, 4'h4, tw[i]); ev(i < 2 ? 3'b010 : 3'b001); rd(4'h4, tx[i]); end
    wb(1, 4'h4, 8'h27);
    fork ev(3'b010); begin @(posedge clk_i); wb(1, 4'h4, 8'h67); end join
    rd(4'h4, 8'h27);
    clock_output_function_cfg_n_i <= 0; wb(1, 4'h4, 8'h80); ev(3'b100);
    `CHK({idle_o, cpu_halt_o, flash_en_o, fosc_periph_en_o, clock_output_function_en_o, wdt_reset_block_o}, 6'h37)
    pulse(3'b100); `CHK(idle_o, 1'b0)
    rd(4'h4, 8'h80); ev(3'b100); `CHK(idle_o, 1'b1)
    pulse(3'b010); `CHK(idle_o, 1'b0)
    wb(1, 4'h4, 8'hE0); ev(3'b100); pulse(3'b010); rd(4'h4, 8'hE0);
    ev(3'b100); pulse(3'b100); rd(4'h4, 8'hA0);
    wb(1, 4'h4, 8'h00); ev(3'b100);
    `CHK({sleep_o, idle_o, fosc_periph_en_o, intosc_periph_en_o}, 4'b1001)
    pulse(3'b001); `CHK(sleep_o, 1'b0)
    conclude();
  end
endmodule
`default_nettype wire
